// [hdl/cde_pkg.sv]
// constants, opcodes and state encoding for the 8-bit decode and execute core
package cde_pkg;
    localparam int          ADDR_W     = 16;
    localparam int          DATA_W     = 8;
    localparam logic [15:0] VEC_NMI    = 16'hFFFA;
    localparam logic [15:0] VEC_RST    = 16'hFFFC;
    localparam logic [15:0] VEC_IRQ    = 16'hFFFE;
    localparam logic [7:0]  STACK_PAGE = 8'h01;
    localparam logic [7:0]  RST_P      = 8'h34;
    localparam logic [7:0]  RST_S      = 8'hFD;
    // status bit positions
    localparam int P_N = 7;
    localparam int P_V = 6;
    localparam int P_U = 5;
    localparam int P_B = 4;
    localparam int P_D = 3;
    localparam int P_I = 2;
    localparam int P_Z = 1;
    localparam int P_C = 0;
    // implemented opcodes, and OP_STOP and OP_LDXI, which are only named and pass as implied ops
    localparam logic [7:0] OP_BRK    = 8'h00;
    localparam logic [7:0] OP_TRB_ZP = 8'h14;
    localparam logic [7:0] OP_TRB_AB = 8'h1C;
    localparam logic [7:0] OP_RTI    = 8'h40;
    localparam logic [7:0] OP_JMP    = 8'h4C;
    localparam logic [7:0] OP_CLI    = 8'h58;
    localparam logic [7:0] OP_ADC    = 8'h69;
    localparam logic [7:0] OP_JMPI   = 8'h6C;
    localparam logic [7:0] OP_SEI    = 8'h78;
    localparam logic [7:0] OP_LDA    = 8'hA9;
    localparam logic [7:0] OP_LDAX   = 8'hBD;
    localparam logic [7:0] OP_WAI    = 8'hCB;
    localparam logic [7:0] OP_STOP   = 8'hDB;
    localparam logic [7:0] OP_CLD    = 8'hD8;
    localparam logic [7:0] OP_SBC    = 8'hE9;
    localparam logic [7:0] OP_SED    = 8'hF8;
    localparam logic [7:0] OP_INCX   = 8'hFE;
    localparam logic [7:0] OP_LDXI   = 8'hA2;
    // no-operation length: bytes in [5:4], cycles in [3:0]; zero marks a defined opcode
    localparam logic [5:0] NOP_NONE = 6'h00;
    localparam logic [5:0] NOP_1_1  = 6'h11;
    localparam logic [5:0] NOP_2_2  = 6'h22;
    localparam logic [5:0] NOP_2_3  = 6'h23;
    localparam logic [5:0] NOP_2_4  = 6'h24;
    localparam logic [5:0] NOP_3_8  = 6'h38;
    localparam logic [5:0] NOP_3_4  = 6'h34;

    typedef enum logic [3:0] {
        ST_FETCH = 4'h0,
        ST_OPLO  = 4'h1,
        ST_OPHI  = 4'h2,
        ST_FIX   = 4'h3,
        ST_RD1   = 4'h4,
        ST_RD2   = 4'h5,
        ST_WR    = 4'h6,
        ST_NOP   = 4'h7,
        ST_DEC   = 4'h8,
        ST_JIL   = 4'h9,
        ST_JFIX  = 4'hA,
        ST_JIH   = 4'hB,
        ST_PUSH  = 4'hC,
        ST_VEC   = 4'hD,
        ST_RTI   = 4'hE,
        ST_WAIT  = 4'hF
    } cde_state_e;

    function automatic logic [5:0] cde_nop_len(input logic [7:0] op);
        logic [5:0] r;
        r = NOP_NONE;
        if (op[3:0] == 4'h2 && !op[4] && op != OP_LDXI) r = NOP_2_2;
        else if (op[3:0] == 4'h3) r = NOP_1_1;
        else if (op[3:0] == 4'hB && op != OP_WAI && op != OP_STOP) r = NOP_1_1;
        else if (op == 8'h44) r = NOP_2_3;
        else if (op == 8'h54 || op == 8'hD4 || op == 8'hF4) r = NOP_2_4;
        else if (op == 8'h5C) r = NOP_3_8;
        else if (op == 8'hDC || op == 8'hFC) r = NOP_3_4;
        return r;
    endfunction
endpackage

// [hdl/cde_core.sv]
// 8-bit processor decode and execute core with bus, ready pin and interrupts
`timescale 1ns/10ps
module cde_core (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_resetn,
    input  wire logic [cde_pkg::DATA_W-1:0] i_data,
    input  wire logic                       i_rdy_i,
    input  wire logic                       i_irq_n,
    input  wire logic                       i_nmi_n,
    output logic      [cde_pkg::ADDR_W-1:0] o_addr,
    output logic      [cde_pkg::DATA_W-1:0] o_data,
    output logic                            o_rw,
    output logic                            o_sync,
    output logic                            o_rdy_o,
    output logic                            o_rdy_oe,
    output logic      [cde_pkg::DATA_W-1:0] o_acc,
    output logic      [cde_pkg::DATA_W-1:0] o_flags
);
    import cde_pkg::*;

    typedef struct packed {
        cde_state_e  st;
        logic [2:0]  cnt;
        logic [15:0] pc;
        logic [15:0] addr;
        logic [7:0]  a;
        logic [7:0]  x;
        logic [7:0]  s;
        logic [7:0]  p;
        logic [7:0]  ir;
        logic [7:0]  lo;
        logic [7:0]  hi;
        logic [7:0]  m;
        logic [7:0]  dout;
        logic        rw;
        logic        sync;
        logic        hw;
        logic        rdy_oe;
        logic [1:0]  own;
        logic        irq_s1;
        logic        irq_s2;
        logic        nmi_s1;
        logic        nmi_s2;
        logic        nmi_prev;
        logic        nmi_pend;
        logic        rdy_s1;
        logic        rdy_s2;
    } cde_core_s;

    localparam cde_core_s RST_STATE = '{st: ST_VEC, addr: VEC_RST, p: RST_P, s: RST_S,
                                        rw: 1'b1, irq_s1: 1'b1, irq_s2: 1'b1,
                                        nmi_s1: 1'b1, nmi_s2: 1'b1, nmi_prev: 1'b1,
                                        rdy_s1: 1'b1, rdy_s2: 1'b1, default: '0};

    cde_core_s   q;
    cde_core_s   d;
    logic [1:0]  rst_sync_q;
    logic        rst_n;
    logic        stall;
    logic        int_go;
    logic        nmi_edge;
    logic        do_alu;
    logic [8:0]  sum;
    logic [9:0]  av;
    logic [5:0]  nl;
    logic [5:0]  nl_q;
    logic [7:0]  op;
    logic [7:0]  res;

    // binary or decimal add/subtract; returns {overflow, carry, result}
    function automatic logic [9:0] alu(input logic [7:0] a, input logic [7:0] m,
                                       input logic ci, input logic dec, input logic sub);
        logic [7:0] mm;
        logic [8:0] bin;
        logic [8:0] r;
        logic [4:0] lo;
        logic       v;
        mm  = sub ? ~m : m;
        bin = {1'b0, a} + {1'b0, mm} + {8'h00, ci};
        v   = (a[7] == mm[7]) && (bin[7] != a[7]);
        r   = bin;
        lo  = 5'h00;
        if (dec && !sub) begin
            lo = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, ci};
            if (lo > 5'h09) r = r + 9'h006;
            if (r[8:4] > 5'h09) r = r + 9'h060;
        end else if (dec) begin
            lo = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~ci};
            if (lo[4]) r = {r[8], r[7:0] - 8'h06};
            if (!bin[8]) r = {r[8], r[7:0] - 8'h60};
        end
        return {v, r};
    endfunction

    function automatic cde_core_s go_fetch(input cde_core_s v, input logic [15:0] a,
                                           input logic go);
        v.pc   = a;
        v.addr = a;
        v.rw   = 1'b1;
        v.sync = 1'b1;
        v.hw   = go;
        v.st   = ST_FETCH;
        return v;
    endfunction

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) rst_sync_q <= 2'b00;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // own drive of the ready line must not stall us while it echoes back through the syncs
    assign stall    = ~q.rdy_s2 & ~q.rdy_oe & ~|q.own;
    assign int_go   = q.nmi_pend | (~q.irq_s2 & ~q.p[P_I]);
    assign nmi_edge = q.nmi_prev & ~q.nmi_s2;
    assign sum      = {1'b0, q.lo} + {1'b0, q.x};
    assign nl_q     = cde_nop_len(q.ir);
    assign av       = alu(q.a, (q.st == ST_DEC) ? q.m : i_data, q.p[P_C],
                          q.p[P_D], q.ir == OP_SBC);

    always_comb begin
        d          = q;
        do_alu     = 1'b0;
        op         = q.hw ? OP_BRK : i_data;
        nl         = cde_nop_len(op);
        res        = 8'h00;
        d.irq_s1   = i_irq_n;
        d.irq_s2   = q.irq_s1;
        d.nmi_s1   = i_nmi_n;
        d.nmi_s2   = q.nmi_s1;
        d.nmi_prev = q.nmi_s2;
        d.rdy_s1   = i_rdy_i;
        d.rdy_s2   = q.rdy_s1;
        d.own      = {q.own[0], q.rdy_oe};
        d.nmi_pend = q.nmi_pend | nmi_edge;
        if (!stall) begin
            d.sync = 1'b0;
            unique case (q.st)
                ST_FETCH: begin
                    d.ir  = op;
                    d.pc  = q.hw ? q.pc : q.pc + 16'h0001;
                    d.addr = d.pc;
                    d.cnt = 3'd1;
                    if (nl == NOP_1_1) d = go_fetch(d, d.pc, int_go);
                    else if (nl != NOP_NONE) d.st = ST_NOP;
                    else d.st = ST_OPLO;
                end
                ST_NOP: begin
                    // registers and flags untouched, only the program counter moves
                    if ({1'b0, q.cnt} < {2'b00, nl_q[5:4]}) d.pc = q.pc + 16'h0001;
                    d.addr = d.pc;
                    d.cnt  = q.cnt + 3'd1;
                    if ({1'b0, q.cnt} == nl_q[3:0] - 4'd1) begin
                        d = go_fetch(d, d.pc, int_go);
                    end
                end
                ST_OPLO: begin
                    d.cnt = 3'd0;
                    unique case (q.ir)
                        OP_LDA, OP_ADC, OP_SBC: begin
                            d.pc = q.pc + 16'h0001;
                            if (q.ir == OP_LDA) begin
                                d.a      = i_data;
                                d.p[P_N] = i_data[7];
                                d.p[P_Z] = (i_data == 8'h00);
                                d = go_fetch(d, d.pc, int_go);
                            end else if (q.p[P_D]) begin
                                d.m    = i_data;
                                d.addr = d.pc;
                                d.st   = ST_DEC;
                            end else begin
                                do_alu = 1'b1;
                                d = go_fetch(d, d.pc, int_go);
                            end
                        end
                        OP_TRB_AB, OP_JMP, OP_JMPI, OP_LDAX, OP_INCX: begin
                            d.lo   = i_data;
                            d.pc   = q.pc + 16'h0001;
                            d.addr = d.pc;
                            d.st   = ST_OPHI;
                        end
                        OP_TRB_ZP: begin
                            d.lo   = i_data;
                            d.pc   = q.pc + 16'h0001;
                            d.addr = {8'h00, i_data};
                            d.st   = ST_RD1;
                        end
                        OP_BRK: begin
                            if (!q.hw) d.pc = q.pc + 16'h0001;
                            d.addr = {STACK_PAGE, q.s};
                            d.rw   = 1'b0;
                            d.dout = d.pc[15:8];
                            d.st   = ST_PUSH;
                        end
                        OP_RTI: begin
                            d.addr = {STACK_PAGE, q.s};
                            d.st   = ST_RTI;
                        end
                        OP_WAI: begin
                            d.rdy_oe = 1'b1;
                            d.addr   = q.pc;
                            d.st     = ST_WAIT;
                        end
                        OP_SED, OP_CLD, OP_SEI, OP_CLI: begin
                            if (q.ir == OP_SED || q.ir == OP_CLD) d.p[P_D] = q.ir == OP_SED;
                            else d.p[P_I] = q.ir == OP_SEI;
                            d = go_fetch(d, q.pc, int_go);
                        end
                        // other defined opcodes are outside this core and pass as implied ops
                        default: d = go_fetch(d, q.pc, int_go);
                    endcase
                end
                ST_DEC: begin
                    do_alu = 1'b1;
                    d = go_fetch(d, q.pc, int_go);
                end
                ST_OPHI: begin
                    d.hi   = i_data;
                    d.pc   = q.pc + 16'h0001;
                    d.addr = {i_data, q.lo};
                    d.st   = (q.ir == OP_JMPI) ? ST_JIL : ST_RD1;
                    if (q.ir == OP_JMP) begin
                        d = go_fetch(d, {i_data, q.lo}, int_go);
                    end else if (q.ir == OP_LDAX || q.ir == OP_INCX) begin
                        d.lo = sum[7:0];
                        if (sum[8]) begin
                            d.addr = q.pc;
                            d.st   = ST_FIX;
                        end else begin
                            d.addr = {i_data, sum[7:0]};
                        end
                    end
                end
                ST_FIX: begin
                    d.hi   = q.hi + 8'h01;
                    d.addr = {q.hi + 8'h01, q.lo};
                    d.st   = ST_RD1;
                end
                ST_RD1: begin
                    if (q.ir == OP_LDAX) begin
                        d.a      = i_data;
                        d.p[P_N] = i_data[7];
                        d.p[P_Z] = (i_data == 8'h00);
                        d = go_fetch(d, q.pc, int_go);
                    end else begin
                        d.st = ST_RD2;
                    end
                end
                ST_RD2: begin
                    if (q.ir == OP_INCX) begin
                        res      = i_data + 8'h01;
                        d.p[P_N] = res[7];
                        d.p[P_Z] = (res == 8'h00);
                    end else begin
                        res      = i_data & ~q.a;
                        d.p[P_Z] = ((i_data & q.a) == 8'h00);
                    end
                    d.dout = res;
                    d.rw   = 1'b0;
                    d.st   = ST_WR;
                end
                ST_WR: d = go_fetch(d, q.pc, int_go);
                ST_JIL: begin
                    d.m = i_data;
                    if (q.lo == 8'hFF) begin
                        d.st = ST_JFIX;
                    end else begin
                        d.addr = {q.hi, q.lo + 8'h01};
                        d.st   = ST_JIH;
                    end
                end
                ST_JFIX: begin
                    d.addr = {q.hi + 8'h01, 8'h00};
                    d.st   = ST_JIH;
                end
                ST_JIH: d = go_fetch(d, {i_data, q.m}, int_go);
                ST_PUSH: begin
                    d.s    = q.s - 8'h01;
                    d.addr = {STACK_PAGE, d.s};
                    d.cnt  = q.cnt + 3'd1;
                    if (q.cnt == 3'd0) begin
                        d.dout = q.pc[7:0];
                    end else if (q.cnt == 3'd1) begin
                        d.dout      = q.p;
                        d.dout[P_U] = 1'b1;
                        d.dout[P_B] = ~q.hw;
                    end else begin
                        d.rw     = 1'b1;
                        d.p[P_I] = 1'b1;
                        d.p[P_D] = 1'b0;
                        d.cnt    = 3'd0;
                        d.st     = ST_VEC;
                        // a software break keeps its own vector; a late interrupt waits
                        if (q.hw && q.nmi_pend) begin
                            d.addr     = VEC_NMI;
                            d.nmi_pend = nmi_edge;
                        end else begin
                            d.addr = VEC_IRQ;
                        end
                    end
                end
                ST_VEC: begin
                    d.m    = i_data;
                    d.addr = q.addr + 16'h0001;
                    d.cnt  = 3'd1;
                    if (q.cnt != 3'd0) d = go_fetch(d, {i_data, q.m}, int_go);
                end
                ST_RTI: begin
                    d.s    = q.s + 8'h01;
                    d.addr = {STACK_PAGE, d.s};
                    d.cnt  = q.cnt + 3'd1;
                    if (q.cnt == 3'd1) begin
                        d.p      = i_data;
                        d.p[P_U] = 1'b1;
                        d.p[P_B] = 1'b1;
                    end
                    if (q.cnt == 3'd2) d.m = i_data;
                    if (q.cnt == 3'd3) begin
                        d.s = q.s;
                        d = go_fetch(d, {i_data, q.m}, int_go);
                    end
                end
                ST_WAIT: begin
                    // a masked request still ends the wait, then execution simply resumes
                    if (q.nmi_pend || !q.irq_s2) begin
                        d.rdy_oe = 1'b0;
                        d = go_fetch(d, q.pc, int_go);
                    end
                end
            endcase
            if (do_alu) begin
                d.a      = av[7:0];
                d.p[P_C] = av[8];
                d.p[P_V] = av[9];
                d.p[P_N] = av[7];
                d.p[P_Z] = (av[7:0] == 8'h00);
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) q <= RST_STATE;
        else q <= d;
    end

    assign o_addr   = q.addr;
    assign o_data   = q.dout;
    assign o_rw     = q.rw;
    assign o_sync   = q.sync;
    assign o_rdy_o  = 1'b0;
    assign o_rdy_oe = q.rdy_oe;
    assign o_acc    = q.a;
    assign o_flags  = q.p;
endmodule // cde_core

// [bench/cde_mem.sv]
// behavioural memory and ready-line model on the far side of the core bus
`timescale 1ns/10ps
module cde_mem (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_rw,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_hold,
    input  wire logic        i_rdy_o,
    input  wire logic        i_rdy_oe,
    output logic      [7:0]  o_rdata,
    output logic             o_rdy
);
    logic [7:0] ram [0:65535];
    // the bus is not driven during writes, so show the inverse rather than a stale byte
    assign o_rdata = i_rw ? ram[i_addr] : ~i_wdata;
    // pulled up when idle; the system drives through a resistor so the core can win
    assign o_rdy = (i_rdy_oe && !i_rdy_o) ? 1'b0 : !i_hold;
    always @(posedge i_clk) begin
        if (!i_rw) ram[i_addr] <= i_wdata;
    end
endmodule // cde_mem

// [bench/cde_chk_sva.sv]
// port-level assertions for the decode and execute core
`timescale 1ns/10ps
module cde_chk (
    input wire logic        i_ref_clk,
    input wire logic        i_resetn,
    input wire logic [7:0]  i_data,
    input wire logic        i_rdy_i,
    input wire logic        i_irq_n,
    input wire logic        i_nmi_n,
    input wire logic [15:0] o_addr,
    input wire logic [7:0]  o_data,
    input wire logic        o_rw,
    input wire logic        o_sync,
    input wire logic        o_rdy_o,
    input wire logic        o_rdy_oe,
    input wire logic [7:0]  o_acc,
    input wire logic [7:0]  o_flags
);
    import cde_pkg::*;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);
    // ready high long enough that the fetch cannot be stalled by the synchroniser
    sequence s_go;
        i_rdy_i [*3] ##0 o_sync;
    endsequence
    sequence s_nop2;
        s_go ##0 (i_data[4:0] == 5'h02 && i_data != 8'hA2);
    endsequence
    sequence s_rmw;
        o_rw ##1 (o_rw && $stable(o_addr)) ##1 (!o_rw && $stable(o_addr)) ##1 o_sync;
    endsequence
    chk_nop_len: assert property (s_nop2 |=> !o_sync ##1
        (o_sync && o_addr == $past(o_addr, 2) + 16'h0002)) else $error("nop2 length");
    chk_nop_quiet: assert property (s_nop2 |=>
        ($stable(o_acc) && $stable(o_flags)) [*2]) else $error("nop changed state");
    chk_jmp_wrap: assert property (s_go ##0 (i_data == 8'h6C) ##1 (i_data == 8'hFF)
        |=> ##3 (o_addr == {$past(o_addr[15:8], 2) + 8'h01, 8'h00}) ##1 o_sync)
        else $error("pointer page carry");
    chk_rmw_seq: assert property (s_go ##0 (i_data == 8'hFE || i_data == 8'h1C)
        |=> ##2 s_rmw) else $error("rmw bus order");
    chk_trb_data: assert property (s_go ##0 (i_data == 8'h1C) |=> ##4
        (!o_rw && o_data == ($past(i_data) & ~o_acc))) else $error("bit clear data");
    chk_dec_slow: assert property (s_go ##0 (i_data == 8'h69 && o_flags[P_D])
        |=> !o_sync [*2] ##1 o_sync) else $error("decimal add length");
    chk_bin_fast: assert property (s_go ##0 (i_data == 8'h69 && !o_flags[P_D])
        |=> !o_sync ##1 o_sync) else $error("binary add length");
    chk_brk_vec: assert property (s_go ##0 (i_data == 8'h00) |=> ##4 (o_addr == VEC_IRQ)
        ##1 (o_addr == 16'hFFFF) ##1 (o_sync && !o_flags[P_D])) else $error("break sequence");
    chk_wai_drive: assert property (s_go ##0 (i_data == 8'hCB) |=> ##1
        (o_rdy_oe && !o_rdy_o)) else $error("wait not driving ready");
    chk_stall_hold: assert property ((!i_rdy_i && !o_rdy_oe) [*4] |->
        $stable(o_addr) && $stable(o_rw)) else $error("bus moved in stall");
endmodule // cde_chk

bind cde_core cde_chk u_chk (.i_ref_clk, .i_resetn, .i_data, .i_rdy_i, .i_irq_n, .i_nmi_n,
    .o_addr, .o_data, .o_rw, .o_sync, .o_rdy_o, .o_rdy_oe, .o_acc, .o_flags);

// [bench/tb_cpu8_decode_exec_behaviour.sv]
// self-checking bench: program in the memory model, cycle counts and results compared
`timescale 1ns/10ps
module tb_cpu8_decode_exec_behaviour;
    import cde_pkg::*;
    logic        i_ref_clk = 1'b0;
    logic        i_resetn  = 1'b0;
    logic        i_irq_n   = 1'b1;
    logic        i_nmi_n   = 1'b1;
    logic        hold      = 1'b0;
    logic        rdy, o_rw, o_sync, o_rdy_o, o_rdy_oe;
    logic [7:0]  rdata, o_data, o_acc, o_flags, ra, rb, rc, rm, ri, fl;
    logic [8:0]  dsum;
    logic [15:0] o_addr, pc, a;
    logic [7:0]  ops[$];
    int          n;
    int          rd_cnt      = 0;
    int          wr_cnt      = 0;
    int          num_errors  = 0;
    int          checks_done = 0;

    cde_core dut (.i_ref_clk, .i_resetn, .i_data(rdata), .i_rdy_i(rdy), .i_irq_n, .i_nmi_n,
                  .o_addr, .o_data, .o_rw, .o_sync, .o_rdy_o, .o_rdy_oe, .o_acc, .o_flags);
    cde_mem mem (.i_clk(i_ref_clk), .i_addr(o_addr), .i_rw(o_rw), .i_wdata(o_data),
                 .i_hold(hold), .i_rdy_o(o_rdy_o), .i_rdy_oe(o_rdy_oe), .o_rdata(rdata),
                 .o_rdy(rdy));

    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // accesses at the increment target, to count reads against writes
    always @(negedge i_ref_clk) begin
        if (o_addr == 16'h0310 && o_rw === 1'b1) rd_cnt++;
        if (o_addr == 16'h0310 && o_rw === 1'b0) wr_cnt++;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic load(input logic [15:0] at, input logic [7:0] b[$]);
        pc = at;
        foreach (b[i]) begin
            mem.ram[pc] = b[i];
            pc++;
        end
    endtask

    // counts negedges up to the next opcode fetch; a hang shows as a wrong count
    task automatic next_op(output logic [15:0] ad, output int cyc);
        cyc = 0;
        do begin
            @(negedge i_ref_clk);
            cyc++;
        end while (o_sync !== 1'b1 && cyc < 40);
        ad = o_addr;
    endtask

    // bytes in the upper digit, cycles in the lower
    function automatic int nop_len(input logic [7:0] op);
        case (op)
            8'h44: return 8'h23;
            8'h54, 8'hD4, 8'hF4: return 8'h24;
            8'h5C: return 8'h38;
            8'hDC, 8'hFC: return 8'h34;
            default: return (op[3:0] == 4'h2) ? 8'h22 : 8'h11;
        endcase
    endfunction

    function automatic logic [8:0] bcd_add(input logic [7:0] x, input logic [7:0] y);
        int s;
        s = x[7:4] * 10 + x[3:0] + y[7:4] * 10 + y[3:0];
        return {s >= 100, 4'((s % 100) / 10), 4'(s % 10)};
    endfunction

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        #20000;
        num_errors++;
        summarize();
    end

    initial begin
        void'($urandom(32'hDA55D9CD));
        for (int i = 0; i < 65536; i++) mem.ram[i] = 8'hEA;
        ops = '{8'h02, 8'h22, 8'h42, 8'h62, 8'h82, 8'hC2, 8'hE2, 8'h0B, 8'hEB, 8'hFB, 8'h44,
                8'h54, 8'hD4, 8'hF4, 8'h5C, 8'hDC, 8'hFC};
        ops.push_back({4'($urandom_range(15)), 4'h3});
        ops.push_back({4'($urandom_range(11)), 4'hB});
        ops.shuffle();
        pc = 16'h0200;
        foreach (ops[i]) begin
            mem.ram[pc] = ops[i];
            pc++;
            repeat (nop_len(ops[i]) / 16 - 1) begin
                mem.ram[pc] = 8'($urandom);
                pc++;
            end
        end
        ra = {4'($urandom_range(9)), 4'($urandom_range(9))};
        rb = {4'($urandom_range(9)), 4'($urandom_range(9))};
        rc = 8'($urandom);
        rm = 8'($urandom);
        ri = 8'($urandom);
        mem.ram[16'h0300] = rm;
        mem.ram[16'h0310] = ri;
        load(pc, '{8'hA9, ra, 8'h1C, 8'h00, 8'h03, 8'hF8, 8'hFE, 8'h10, 8'h03, 8'h69, rb,
                   8'hD8, 8'h69, rc, 8'h6C, 8'hFF, 8'h04});
        load(16'h04FF, '{8'h00, 8'h06});
        load(16'h0600, '{8'hCB, 8'hF8, 8'h00, 8'h5A});
        load(16'h0700, '{8'h4C, 8'h00, 8'h07});
        load(16'h0800, '{8'h4C, 8'h00, 8'h08});
        load(16'hFFFA, '{8'h00, 8'h08, 8'h00, 8'h02, 8'h00, 8'h07});
        repeat (2) @(negedge i_ref_clk);
        chk(o_addr, VEC_RST, "reset address");
        chk(16'(o_flags[P_D]), 16'h0000, "decimal at reset");
        i_resetn = 1'b1;
        next_op(a, n);
        chk(a, 16'h0200, "first fetch");
        pc = 16'h0200;
        foreach (ops[i]) begin
            pc += 16'(nop_len(ops[i]) / 16);
            next_op(a, n);
            chk(a, pc, "nop length");
            chk(16'(n), 16'(nop_len(ops[i]) % 16), "nop cycles");
            chk({o_acc, o_flags}, {8'h00, RST_P}, "nop side effect");
        end
        next_op(a, n);
        next_op(a, n);
        chk(16'(n), 16'h0006, "bit clear cycles");
        next_op(a, n);
        fl = RST_P;
        fl[P_N] = ra[7];
        fl[P_Z] = (ra & rm) == 8'h00;
        fl[P_D] = 1'b1;
        chk({o_acc, o_flags}, {ra, fl}, "bit clear flags");
        chk(16'(mem.ram[16'h0300]), 16'(rm & ~ra), "bit clear memory");
        next_op(a, n);
        chk(16'(n), 16'h0006, "rmw same page cycles");
        chk(16'(rd_cnt * 16 + wr_cnt), 16'h0021, "rmw reads and writes");
        chk(16'(mem.ram[16'h0310]), 16'(8'(ri + 8'h01)), "increment result");
        next_op(a, n);
        chk(16'(n), 16'h0003, "decimal add cycles");
        next_op(a, n);
        dsum = bcd_add(ra, rb);
        chk(16'({o_acc, o_flags[P_N], o_flags[P_Z], o_flags[P_C]}),
            16'({dsum[7:0], dsum[7], dsum[7:0] == 8'h00, dsum[8]}), "decimal add");
        next_op(a, n);
        chk(16'(n), 16'h0002, "binary add cycles");
        next_op(a, n);
        chk(a, 16'h0600, "indirect target");
        chk(16'(n), 16'h0006, "indirect cycles");
        chk(16'(o_acc), 16'(8'(dsum[7:0] + rc + 8'(dsum[8]))), "binary add");
        repeat (4) @(negedge i_ref_clk);
        chk(16'({o_rdy_oe, rdy}), 16'h0002, "wait drives ready");
        i_irq_n = 1'b0;
        next_op(a, n);
        chk(a, 16'h0601, "masked irq ends wait");
        i_irq_n = 1'b1;
        next_op(a, n);
        i_nmi_n = 1'b0;
        next_op(a, n);
        chk(a, 16'h0700, "break vector first");
        chk(16'(n), 16'h0007, "break cycles");
        next_op(a, n);
        i_nmi_n = 1'b1;
        chk(a, 16'h0800, "nmi after break");
        chk({mem.ram[16'h01FD], mem.ram[16'h01FC]}, 16'h0604, "break return");
        chk(16'({mem.ram[16'h01FB][P_B], mem.ram[16'h01F8][P_B]}), 16'h0002, "break bit");
        chk({mem.ram[16'h01FA], mem.ram[16'h01F9]}, 16'h0700, "nmi return");
        chk(16'(o_flags[P_D]), 16'h0000, "decimal after interrupt");
        hold = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        a = o_addr;
        repeat (4) @(negedge i_ref_clk);
        chk(o_addr, a, "stall holds bus");
        hold = 1'b0;
        repeat (4) @(negedge i_ref_clk);
        summarize();
    end
endmodule // tb_cpu8_decode_exec_behaviour
